// ### door_drive_mode_supervisor.sv
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Function
// - Slow profile only with valid order, slow bit set and normal mode.
// - Slow profile may toggle while moving; speed ramps to new target.
// - Initial or learn mode uses fixed speeds, ignoring profile speed settings.
// - Initial mode, sensor active, order present: obstruction ends run, adopt status.
// - Fieldbus sensor value valid only in the operating state.
// - Local input 1 carries at most one sensor function at a time.
// - Power-up enters initial mode until both end stops verified.
// - Initial mode uses initial speed settings and static force limits.
// - End stop recognised when position lies within width tolerance.
// - Sequential control starts in switching-on-inhibited state.
// - High load from rapid commands delays closing and shows code 4.
// - Continuous travel one direction over 65 s raises fault 4.
// - De-energised over trigger speed: brake to 50 mm/s, then release.
// - New motor types use 200 mm/s trigger speed while the limit keeps its 250 mm/s reset value.
// - Trigger speed from limit setting; zero disables monitoring.
// - Belt break when travel exceeds door width plus margin.
// - Margin zero suppresses belt-break detection and fault.
// - Belt break shows code t and enters fault state.
// - Invalid parameter set uses 5 m door width.
// - With end sensor, restart from closed at normal speed at once.
module door_drive_mode_supervisor
  import door_supervisor_pkg::*;
#(
  parameter int MS_CYCLES = MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Drive orders, sensors and motor feedback
  input wire drive_in_t drv_in,
  // Drive control and status
  output drive_out_t drv_out,
  output mode_t mode,
  output seq_t seq_state,
  output disp_t segment_display
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_t mode;
    seq_t seq;
    disp_t disp;
    logic open_seen;
    logic closed_seen;
    logic door_open;
    logic door_closed;
    logic brake;
    logic last_moving;
    logic last_dir;
    logic last_order_open;
    logic [7:0] load;
    logic [15:0] ms_cnt;
    logic [9:0] sec_ms;
    logic [7:0] run_s;
    logic [DATA_W-1:0] spd;
    logic [DATA_W-1:0] start_pos;
    logic [DATA_W-1:0] rdata;
    logic [3:0] ctrl;
    logic [DATA_W-1:0] unpow_limit;
    logic [DATA_W-1:0] belt_margin;
    logic [DATA_W-1:0] tol;
    logic [DATA_W-1:0] init_open;
    logic [DATA_W-1:0] init_close;
    logic [DATA_W-1:0] norm_spd;
    logic [DATA_W-1:0] slow_spd;
    logic [DATA_W-1:0] force_open;
    logic [DATA_W-1:0] force_close;
    logic [DATA_W-1:0] width;
    logic [DATA_W-1:0] ramp;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ----------------------------------------------------------------
  // Derived terms
  // ----------------------------------------------------------------
  input_fn_t fn_sel;
  logic order_valid;
  logic sensor_valid;
  logic ms_tick;
  logic sec_tick;
  logic [DATA_W-1:0] target;
  logic [DATA_W-1:0] trigger;
  logic [DATA_W-1:0] eff_width;
  logic [DATA_W:0] belt_limit;
  logic [DATA_W-1:0] travel;
  logic belt_break;
  logic run_over;
  logic at_closed;
  logic at_open;

  // Function select lives in the control register; one value means one function
  assign fn_sel = input_fn_t'(s_q.ctrl[CTRL_FN_LSB +: 2]);
  assign order_valid = drv_in.order_open | drv_in.order_close;
  // Fieldbus copy only counts in the operating state, local copy only if selected
  assign sensor_valid = (fn_sel == FN_END_POS && drv_in.local_input_1) ||
                        (s_q.seq == OPERATING_STATE && drv_in.end_position_sensor);
  assign ms_tick = (s_q.ms_cnt == 16'(MS_CYCLES - 1));
  assign sec_tick = ms_tick && (s_q.sec_ms == 10'(MS_PER_S - 1));

  // Speed target: initial mode ignores both profile speed settings
  always_comb begin
    if (!order_valid) begin
      target = '0;
    end else if (s_q.mode == MODE_INITIAL) begin
      target = drv_in.order_open ? s_q.init_open : s_q.init_close;
    end else if (drv_in.slow_bit) begin
      target = s_q.slow_spd;
    end else begin
      target = s_q.norm_spd;
    end
  end

  // Trigger speed: a zero limit switches monitoring off altogether
  always_comb begin
    if (s_q.unpow_limit == '0) begin
      trigger = '0;
    end else if (drv_in.new_motor_type && s_q.unpow_limit == UNPOW_LIMIT_RST) begin
      trigger = UNPOW_NEW_MOTOR;
    end else begin
      trigger = s_q.unpow_limit;
    end
  end

  // Belt check distance; the worst-case width covers a lost parameter set
  assign eff_width = drv_in.param_valid ? s_q.width : INVALID_WIDTH;
  assign belt_limit = {1'b0, eff_width} + {1'b0, s_q.belt_margin};
  assign travel = (drv_in.position >= s_q.start_pos) ? drv_in.position - s_q.start_pos :
                  s_q.start_pos - drv_in.position;
  assign belt_break = drv_in.moving && s_q.last_moving && (s_q.belt_margin != '0) &&
                      ({1'b0, travel} > belt_limit) && (s_q.seq != FAULT_STATE);
  assign run_over = (s_q.run_s > 8'(RUN_LIMIT_S)) && (s_q.seq != FAULT_STATE);
  // End-stop windows around the learned positions
  assign at_closed = drv_in.position <= s_q.tol;
  assign at_open = ({1'b0, drv_in.position} + {1'b0, s_q.tol} >= {1'b0, s_q.width}) &&
                   ({1'b0, drv_in.position} <= {1'b0, s_q.width} + {1'b0, s_q.tol});

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.last_moving = drv_in.moving;
    s_d.last_dir = drv_in.dir_open;
    s_d.last_order_open = drv_in.order_open;

    // Millisecond and second dividers
    s_d.ms_cnt = ms_tick ? '0 : s_q.ms_cnt + 16'h0001;
    if (ms_tick) begin
      s_d.sec_ms = (s_q.sec_ms == 10'(MS_PER_S - 1)) ? '0 : s_q.sec_ms + 10'h001;
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: s_d.ctrl = {1'b0, reg_wdata[CTRL_ENABLE_BIT], reg_wdata[CTRL_FN_LSB +: 2]};
        OFS_UNPOW_LIMIT: s_d.unpow_limit = reg_wdata;
        OFS_BELT_MARGIN: s_d.belt_margin = reg_wdata;
        OFS_TOLERANCE: s_d.tol = reg_wdata;
        OFS_INIT_OPEN: s_d.init_open = reg_wdata;
        OFS_INIT_CLOSE: s_d.init_close = reg_wdata;
        OFS_NORM_SPD: s_d.norm_spd = reg_wdata;
        OFS_SLOW_SPD: s_d.slow_spd = reg_wdata;
        OFS_FORCE_OPEN: s_d.force_open = reg_wdata;
        OFS_FORCE_CLOSE: s_d.force_close = reg_wdata;
        OFS_WIDTH: s_d.width = reg_wdata;
        OFS_RAMP: s_d.ramp = reg_wdata;
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end

    // Register reads: data stands in the following cycle only
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: s_d.rdata = {12'h000, s_q.ctrl};
        OFS_UNPOW_LIMIT: s_d.rdata = s_q.unpow_limit;
        OFS_BELT_MARGIN: s_d.rdata = s_q.belt_margin;
        OFS_TOLERANCE: s_d.rdata = s_q.tol;
        OFS_INIT_OPEN: s_d.rdata = s_q.init_open;
        OFS_INIT_CLOSE: s_d.rdata = s_q.init_close;
        OFS_NORM_SPD: s_d.rdata = s_q.norm_spd;
        OFS_SLOW_SPD: s_d.rdata = s_q.slow_spd;
        OFS_FORCE_OPEN: s_d.rdata = s_q.force_open;
        OFS_FORCE_CLOSE: s_d.rdata = s_q.force_close;
        OFS_WIDTH: s_d.rdata = s_q.width;
        OFS_RAMP: s_d.rdata = s_q.ramp;
        OFS_STATUS: s_d.rdata = {3'h0, s_q.load[7:4], s_q.mode, s_q.seq, s_q.disp, s_q.open_seen,
                                 s_q.closed_seen, s_q.brake, s_q.door_open};
        default: s_d.rdata = '0;
      endcase
    end

    // Ramp towards the target once per millisecond, also during travel
    if (ms_tick) begin
      if (s_q.spd < target) begin
        s_d.spd = (target - s_q.spd > s_q.ramp) ? s_q.spd + s_q.ramp : target;
      end else if (s_q.spd > target) begin
        s_d.spd = (s_q.spd - target > s_q.ramp) ? s_q.spd - s_q.ramp : target;
      end
    end

    // Unpowered-motion guard: brake until speed falls to the release level
    if (!s_q.brake) begin
      if (drv_in.deenergised && trigger != '0 && drv_in.speed > trigger) begin
        s_d.brake = 1'b1;
      end
    end else if (drv_in.speed <= BRAKE_RELEASE) begin
      s_d.brake = 1'b0;
    end

    // Thermal load estimate: each new opening adds, each second drains
    if (drv_in.order_open && !s_q.last_order_open) begin
      s_d.load = (s_q.load > 8'hff - LOAD_INC) ? 8'hff : s_q.load + LOAD_INC;
    end else if (sec_tick && s_q.load != 8'h00) begin
      s_d.load = s_q.load - 8'h01;
    end

    // Continuous-run timer, restarted by a stop or a reversal
    if (!drv_in.moving || drv_in.dir_open != s_q.last_dir || !s_q.last_moving) begin
      s_d.run_s = '0;
    end else if (sec_tick && s_q.run_s != 8'hff) begin
      s_d.run_s = s_q.run_s + 8'h01;
    end

    // Belt reference point taken at each start and each reversal
    if (drv_in.moving && (!s_q.last_moving || drv_in.dir_open != s_q.last_dir)) begin
      s_d.start_pos = drv_in.position;
    end

    // Display: load warning while no fault is latched
    if (s_q.seq != FAULT_STATE) begin
      s_d.disp = (s_q.load >= LOAD_LIMIT) ? DISP_CODE_4 : DISP_NONE;
    end

    // Mode handling
    if (s_q.mode == MODE_INITIAL) begin
      if (drv_in.obstruction && sensor_valid && order_valid) begin
        s_d.mode = MODE_NORMAL;
        s_d.door_open = drv_in.order_open;
        s_d.door_closed = !drv_in.order_open;
      end else if (sensor_valid && !drv_in.moving && drv_in.order_open) begin
        s_d.mode = MODE_NORMAL;
        s_d.door_closed = 1'b1;
      end else if (drv_in.obstruction) begin
        if (at_closed) begin
          s_d.closed_seen = 1'b1;
        end
        if (at_open) begin
          s_d.open_seen = 1'b1;
        end
      end
      if (s_q.open_seen && s_q.closed_seen) begin
        s_d.mode = MODE_NORMAL;
      end
    end else if (drv_in.obstruction && !drv_in.moving) begin
      s_d.door_open = at_open;
      s_d.door_closed = at_closed;
    end else if (drv_in.moving) begin
      s_d.door_open = 1'b0;
      s_d.door_closed = 1'b0;
    end

    // Sequential control; faults win over the enable, but none is raised in the fault state, so an acknowledge always clears
    case (s_q.seq)
      SWITCH_ON_INHIBITED_STATE: begin
        if (s_q.ctrl[CTRL_ENABLE_BIT]) begin
          s_d.seq = OPERATING_STATE;
        end
      end
      OPERATING_STATE: begin
        if (!s_q.ctrl[CTRL_ENABLE_BIT]) begin
          s_d.seq = SWITCH_ON_INHIBITED_STATE;
        end
      end
      FAULT_STATE: begin
        if (reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTRL_ACK_BIT]) begin
          s_d.seq = SWITCH_ON_INHIBITED_STATE;
          s_d.disp = DISP_NONE;
        end
      end
      default: s_d.seq = SWITCH_ON_INHIBITED_STATE;
    endcase
    if (run_over) begin
      s_d.seq = FAULT_STATE;
      s_d.disp = DISP_CODE_4;
    end
    if (belt_break) begin
      s_d.seq = FAULT_STATE;
      s_d.disp = DISP_CODE_T;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.mode <= MODE_INITIAL;
      s_q.seq <= SWITCH_ON_INHIBITED_STATE;
      s_q.disp <= DISP_NONE;
      s_q.unpow_limit <= UNPOW_LIMIT_RST;
      s_q.belt_margin <= BELT_MARGIN_RST;
      s_q.tol <= TOL_RST;
      s_q.init_open <= INIT_SPD_RST;
      s_q.init_close <= INIT_SPD_RST;
      s_q.norm_spd <= NORM_SPD_RST;
      s_q.slow_spd <= SLOW_SPD_RST;
      s_q.force_open <= FORCE_RST;
      s_q.force_close <= FORCE_RST;
      s_q.width <= WIDTH_RST;
      s_q.ramp <= RAMP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_q.rdata;
  assign mode = s_q.mode;
  assign seq_state = s_q.seq;
  assign segment_display = s_q.disp;
  assign drv_out.slow_active = order_valid && drv_in.slow_bit && s_q.mode == MODE_NORMAL;
  assign drv_out.normal_mode = (s_q.mode == MODE_NORMAL);
  assign drv_out.brake = s_q.brake;
  // Holding the door open longer is how the motor gets to cool
  assign drv_out.close_inhibit = (s_q.load >= LOAD_LIMIT);
  assign drv_out.door_open = s_q.door_open;
  assign drv_out.door_closed = s_q.door_closed;
  assign drv_out.guard_trip = fn_sel == FN_LIGHT_CURTAIN && drv_in.local_input_1;
  assign drv_out.edge_trip = fn_sel == FN_PRESSURE_EDGE && drv_in.local_input_1;
  assign drv_out.speed_set = s_q.spd;
  assign drv_out.force_limit = drv_in.order_open ? s_q.force_open : s_q.force_close;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SLOW_ONLY_NORMAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    drv_out.slow_active |-> (drv_out.normal_mode && target == s_q.slow_spd))
    else $error("slow profile outside normal mode");
  AST_INIT_SPEED: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.mode == MODE_INITIAL && drv_in.order_open) |-> target == s_q.init_open)
    else $error("initial mode not using initial speed");
  AST_RAMP_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ms_tick && target > s_q.spd && target - s_q.spd > s_q.ramp) |=> s_q.spd == $past(s_q.spd) + $past(s_q.ramp))
    else $error("ramp step wrong");
  AST_RUN_FAULT: assert property (@(posedge core_clk) disable iff (!rst_n)
    run_over |=> (s_q.seq == FAULT_STATE && (s_q.disp == DISP_CODE_4 || s_q.disp == DISP_CODE_T)))
    else $error("run limit fault missing");
  AST_BRAKE_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!s_q.brake && drv_in.deenergised && trigger != '0 && drv_in.speed > trigger) |=> s_q.brake)
    else $error("unpowered motion not braked");
  AST_LIMIT_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!s_q.brake && s_q.unpow_limit == '0) |=> !s_q.brake)
    else $error("disabled monitor braked");
  AST_BELT_SUPPRESS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_q.belt_margin == '0 && s_q.disp != DISP_CODE_T) |=> s_q.disp != DISP_CODE_T)
    else $error("belt fault with zero margin");
  AST_BELT_FAULT: assert property (@(posedge core_clk) disable iff (!rst_n)
    belt_break |=> (s_q.seq == FAULT_STATE && s_q.disp == DISP_CODE_T))
    else $error("belt break not reported");
  AST_ONE_FUNCTION: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(drv_out.guard_trip && drv_out.edge_trip))
    else $error("two sensor functions on input 1");

endmodule

// ### door_supervisor_pkg.sv
package door_supervisor_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int MS_TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_PERIOD_US;
  localparam int MS_PER_S = 1000;
  localparam int RUN_LIMIT_S = 65;

  // ----------------------------------------------------------------
  // Speeds and distances (mm/s, mm), force and load settings
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] UNPOW_LIMIT_RST = 16'h00fa;
  localparam logic [DATA_W-1:0] UNPOW_NEW_MOTOR = 16'h00c8;
  localparam logic [DATA_W-1:0] BRAKE_RELEASE = 16'h0032;
  localparam logic [DATA_W-1:0] BELT_MARGIN_RST = 16'h01f4;
  localparam logic [DATA_W-1:0] INVALID_WIDTH = 16'h1388;
  localparam logic [DATA_W-1:0] TOL_RST = 16'h000a;
  localparam logic [DATA_W-1:0] INIT_SPD_RST = 16'h0064;
  localparam logic [DATA_W-1:0] NORM_SPD_RST = 16'h0190;
  localparam logic [DATA_W-1:0] SLOW_SPD_RST = 16'h00c8;
  localparam logic [DATA_W-1:0] FORCE_RST = 16'h004b;
  localparam logic [DATA_W-1:0] WIDTH_RST = 16'h03e8;
  localparam logic [DATA_W-1:0] RAMP_RST = 16'h0002;
  localparam logic [7:0] LOAD_INC = 8'h04;
  localparam logic [7:0] LOAD_LIMIT = 8'h10;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_UNPOW_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BELT_MARGIN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TOLERANCE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_INIT_OPEN = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INIT_CLOSE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_NORM_SPD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SLOW_SPD = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_FORCE_OPEN = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_FORCE_CLOSE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_WIDTH = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_RAMP = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h30;

  // Control register fields
  localparam int CTRL_FN_LSB = 0;
  localparam int CTRL_ENABLE_BIT = 2;
  localparam int CTRL_ACK_BIT = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {MODE_INITIAL, MODE_NORMAL} mode_t;
  typedef enum logic [1:0] {SWITCH_ON_INHIBITED_STATE, OPERATING_STATE, FAULT_STATE} seq_t;
  typedef enum logic [1:0] {DISP_NONE, DISP_CODE_4, DISP_CODE_T} disp_t;
  typedef enum logic [1:0] {FN_NONE, FN_END_POS, FN_LIGHT_CURTAIN, FN_PRESSURE_EDGE} input_fn_t;

  typedef struct packed {
    logic order_open;
    logic order_close;
    logic slow_bit;
    logic end_position_sensor;
    logic local_input_1;
    logic obstruction;
    logic moving;
    logic dir_open;
    logic deenergised;
    logic param_valid;
    logic new_motor_type;
    logic [DATA_W-1:0] speed;
    logic [DATA_W-1:0] position;
  } drive_in_t;

  typedef struct packed {
    logic slow_active;
    logic normal_mode;
    logic brake;
    logic close_inhibit;
    logic door_open;
    logic door_closed;
    logic guard_trip;
    logic edge_trip;
    logic [DATA_W-1:0] speed_set;
    logic [DATA_W-1:0] force_limit;
  } drive_out_t;

endpackage

// ### door_order_source.sv
`timescale 1ns/1ps
module door_order_source
  import door_supervisor_pkg::*;
#(
  parameter int SPAN_MM = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Orders and learned width
  input wire drive_in_t req,
  input wire logic [DATA_W-1:0] width,
  // Image seen by the controller
  output drive_in_t drv
);
  // ------------------------------------------------------------
  // Process image
  // ------------------------------------------------------------
  // Sensor shows only near an end stop, so a blocked door never looks like one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv <= '0;
    end else begin
      drv <= req;
      drv.end_position_sensor <= req.end_position_sensor &&
        (req.position <= SPAN_MM || req.position >= width - SPAN_MM);
    end
  end
endmodule

// ### door_drive_mode_supervisor_tb_top.sv
`timescale 1ns/1ps
module door_drive_mode_supervisor_tb_top
  import door_supervisor_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic core_clk;
  logic rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  drive_in_t req;
  drive_in_t drv_in;
  drive_out_t drv_out;
  mode_t mode;
  seq_t seq_state;
  disp_t segment_display;
  int bad_count;
  int checks;

  // One tick per cycle keeps the 65 s run inside the cycle budget
  door_drive_mode_supervisor #(.MS_CYCLES(1)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drv_in(drv_in),
    .drv_out(drv_out), .mode(mode), .seq_state(seq_state), .segment_display(segment_display));
  door_order_source u_plc (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .width(WIDTH_RST), .drv(drv_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic end_sim;
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_power_up;
    tick(1);
    chk(mode, MODE_INITIAL);
    chk(seq_state, SWITCH_ON_INHIBITED_STATE);
    rd_chk(OFS_NORM_SPD, NORM_SPD_RST);
    rd_chk(8'h3c, 16'h0000);
  endtask
  // Door rests closed with the sensor fitted, as a restart needs
  task automatic t_sensor_start;
    @(posedge core_clk);
    req.order_open <= 1'b1;
    req.slow_bit <= 1'b1;
    req.end_position_sensor <= 1'b1;
    tick(4);
    chk(drv_out.slow_active, 1'b0);
    chk(drv_out.force_limit, FORCE_RST);
    chk(mode, MODE_INITIAL);
    wr(OFS_CTRL, 16'h0004);
    tick(4);
    chk(mode, MODE_NORMAL);
    chk(drv_out.door_closed, 1'b1);
    chk(drv_out.slow_active, 1'b1);
  endtask
  task automatic t_slow_ramp;
    @(posedge core_clk);
    req.end_position_sensor <= 1'b0;
    req.moving <= 1'b1;
    req.dir_open <= 1'b1;
    tick(300);
    chk(drv_out.speed_set, SLOW_SPD_RST);
    req.slow_bit <= 1'b0;
    tick(300);
    chk(drv_out.speed_set, NORM_SPD_RST);
  endtask
  task automatic t_unpowered;
    @(posedge core_clk);
    req <= '{param_valid: 1'b1, deenergised: 1'b1, speed: 16'h012c, default: 0};
    tick(3);
    chk(drv_out.brake, 1'b1);
    req.speed <= BRAKE_RELEASE;
    tick(3);
    chk(drv_out.brake, 1'b0);
    req.new_motor_type <= 1'b1;
    req.speed <= 16'h00e1;
    tick(3);
    chk(drv_out.brake, 1'b1);
    req.speed <= 16'h0000;
    wr(OFS_UNPOW_LIMIT, 16'h0000);
    req.speed <= 16'h012c;
    tick(3);
    chk(drv_out.brake, 1'b0);
    req.speed <= 16'h0000;
  endtask
  // Travel of 1501 mm is one past width plus margin
  task automatic t_belt;
    wr(OFS_BELT_MARGIN, 16'h0000);
    req <= '{param_valid: 1'b1, moving: 1'b1, dir_open: 1'b1, default: 0};
    tick(3);
    req.position <= 16'h0640;
    tick(3);
    chk(seq_state, OPERATING_STATE);
    req.moving <= 1'b0;
    req.position <= 16'h0000;
    wr(OFS_BELT_MARGIN, BELT_MARGIN_RST);
    req.moving <= 1'b1;
    tick(3);
    req.position <= 16'h05dd;
    tick(3);
    chk(seq_state, FAULT_STATE);
    chk(segment_display, DISP_CODE_T);
    req.moving <= 1'b0;
    req.position <= 16'h0000;
    wr(OFS_CTRL, 16'h000c);
    tick(3);
    chk(segment_display, DISP_NONE);
  endtask
  task automatic t_input_fn;
    @(posedge core_clk);
    req.local_input_1 <= 1'b1;
    for (int f = 1; f < 4; f++) begin
      wr(OFS_CTRL, 16'h0004 | 16'(f));
      tick(3);
      chk(drv_out.guard_trip, f == 2);
      chk(drv_out.edge_trip, f == 3);
    end
  endtask
  task automatic t_load;
    repeat (8) begin
      @(posedge core_clk);
      req.order_open <= ~req.order_open;
    end
    tick(3);
    chk(drv_out.close_inhibit, 1'b1);
    chk(segment_display, DISP_CODE_4);
  endtask
  // One tick per cycle: 65 s is 65000 cycles
  task automatic t_long_run;
    wr(OFS_CTRL, 16'h0004);
    req <= '{param_valid: 1'b1, moving: 1'b1, position: 16'h0100, default: 0};
    tick(64000);
    chk(segment_display, DISP_NONE);
    tick(3000);
    chk(segment_display, DISP_CODE_4);
  endtask
  // Mid-run power cycle; request may follow on the next edge
  task automatic restart;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  // Obstruction at the open end with the sensor showing is the end stop
  task automatic t_sensor_end_stop;
    restart();
    wr(OFS_CTRL, 16'h0004);
    req <= '{param_valid: 1'b1, order_open: 1'b1, end_position_sensor: 1'b1, obstruction: 1'b1,
             position: 16'h03e8, default: 0};
    tick(4);
    chk(mode, MODE_NORMAL);
    chk(drv_out.normal_mode, 1'b1);
    chk(drv_out.door_open, 1'b1);
    chk(drv_out.door_closed, 1'b0);
  endtask
  // Reference run without sensor, then belt check on a lost parameter set
  task automatic t_reference_run;
    restart();
    req <= '{param_valid: 1'b1, order_open: 1'b1, slow_bit: 1'b1, moving: 1'b1, dir_open: 1'b1,
             position: 16'h0200, default: 0};
    tick(100);
    chk(drv_out.speed_set, INIT_SPD_RST);
    chk(drv_out.slow_active, 1'b0);
    req.moving <= 1'b0;
    req.obstruction <= 1'b1;
    req.position <= 16'h0005;
    tick(3);
    chk(mode, MODE_INITIAL);
    rd_chk(OFS_STATUS, 16'h0004);
    req.position <= 16'h03f0;
    tick(4);
    chk(mode, MODE_NORMAL);
    req <= '{moving: 1'b1, default: 0};
    tick(3);
    req.position <= 16'h07d0;
    tick(3);
    chk(seq_state, SWITCH_ON_INHIBITED_STATE);
    req.position <= 16'h157d;
    tick(3);
    chk(seq_state, FAULT_STATE);
    chk(segment_display, DISP_CODE_T);
  endtask

  // ------------------------------------------------------------
  // Clock, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req = '{param_valid: 1'b1, default: 0};
    bad_count = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_power_up();
    t_sensor_start();
    t_slow_ramp();
    t_unpowered();
    t_belt();
    t_input_fn();
    t_load();
    t_long_run();
    t_sensor_end_stop();
    t_reference_run();
    end_sim();
  end
  // Whole run is near 68000 cycles
  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    end_sim();
  end
endmodule
